// file: hw/afs_link.sv
`timescale 1ns/1ps
module afs_link (
  input wire logic lclk,
  input wire logic nrst,
  input wire afs_pkg::afs_cfg_s cfg,
  input wire logic rx_pin_in,
  input wire logic tx_pin_in,
  input wire afs_pkg::afs_core_s core_src,
  input wire logic slot_start,
  output logic rx_fs_core,
  output logic tx_fs_core,
  output logic rx_drive,
  output logic tx_drive,
  output logic if1
);

  typedef struct packed {
    afs_pkg::afs_cfg_s cfg_m;
    afs_pkg::afs_cfg_s cfg_r;
    afs_pkg::afs_cfg_s cfg_p;
    afs_pkg::afs_cfg_s cfg_s;
    logic rxp_m;
    logic rxp_s;
    logic txp_m;
    logic txp_s;
    logic rx_fs;
    logic tx_fs;
    logic fs_prev;
    logic of1;
    logic if1;
    logic rx_drv;
    logic tx_drv;
  } afs_link_s;

  afs_link_s st_reg;
  afs_link_s st_next;
  logic tx_src;
  logic rx_src;
  logic sync_ev;
  logic flag_mode;

  // Pin routing, flag update and flag sampling on the bit clock
  always_comb begin
    st_next = st_reg;
    st_next.cfg_m = cfg;
    st_next.cfg_r = st_reg.cfg_m;
    st_next.cfg_p = st_reg.cfg_r;
    // Config bits may land a cycle apart; take the word once two samples agree
    if (st_reg.cfg_r == st_reg.cfg_p) begin
      st_next.cfg_s = st_reg.cfg_r;
    end
    st_next.rxp_m = rx_pin_in;
    st_next.rxp_s = st_reg.rxp_m;
    st_next.txp_m = tx_pin_in;
    st_next.txp_s = st_reg.txp_m;
    tx_src = st_reg.cfg_s.tx_fs_direction ? core_src.tx_fs : st_reg.txp_s;
    rx_src = st_reg.cfg_s.rx_fs_direction ? core_src.rx_fs : st_reg.rxp_s;
    st_next.tx_fs = st_reg.cfg_s.pen & tx_src;
    if (!st_reg.cfg_s.pen) begin
      st_next.rx_fs = 1'b0;
    end else if (st_reg.cfg_s.sync) begin
      st_next.rx_fs = tx_src;
    end else begin
      st_next.rx_fs = rx_src;
    end
    st_next.fs_prev = st_reg.rx_fs;
    flag_mode = st_reg.cfg_s.pen & st_reg.cfg_s.sync & ~st_reg.cfg_s.tx_ext_buffer_option;
    sync_ev = flag_mode & (st_reg.cfg_s.netw ? slot_start : (st_reg.rx_fs & ~st_reg.fs_prev));
    // Output flag moves only on a frame or slot event
    if (sync_ev && st_reg.cfg_s.rx_fs_direction) begin
      st_next.of1 = st_reg.cfg_s.of1;
    end
    if (sync_ev && !st_reg.cfg_s.rx_fs_direction) begin
      st_next.if1 = st_reg.rxp_s;
    end
    if (!st_reg.cfg_s.sync) begin
      st_next.rx_drv = core_src.rx_fs;
    end else if (!st_reg.cfg_s.tx_ext_buffer_option) begin
      st_next.rx_drv = st_reg.of1;
    end else begin
      st_next.rx_drv = core_src.buf_en;
    end
    st_next.tx_drv = core_src.tx_fs;
  end

  // Link-domain state register
  always_ff @(posedge lclk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx_fs_core = st_reg.rx_fs;
  assign tx_fs_core = st_reg.tx_fs;
  assign rx_drive = st_reg.rx_drv;
  assign tx_drive = st_reg.tx_drv;
  assign if1 = st_reg.if1;

  default clocking cb @(posedge lclk); endclocking
  default disable iff (!nrst);

  of1_hold_a: assert property (!sync_ev |=> $stable(st_reg.of1))
    else $error("output flag changed without a sync event");
  if1_sample_a: assert property ((sync_ev && !st_reg.cfg_s.rx_fs_direction) |=> if1 == $past(st_reg.rxp_s))
    else $error("input flag not sampled at sync event");
  shared_fs_a: assert property ((st_reg.cfg_s.pen && st_reg.cfg_s.sync) |=> rx_fs_core == tx_fs_core)
    else $error("receivers not on transmit frame sync in sync mode");

endmodule

// file: hw/afs_pins.sv
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module afs_pins #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic rx_frame_sync_pin_in,
  input wire logic tx_frame_sync_pin_in,
  output afs_pkg::afs_pin_s rx_frame_sync_pin,
  output afs_pkg::afs_pin_s tx_frame_sync_pin,
  input wire afs_pkg::afs_core_s core_src,
  input wire logic slot_start,
  output logic rx_fs_core,
  output logic tx_fs_core
);

  // Offsets need at least five address bits
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W out of range");
  end

  typedef struct packed {
    afs_pkg::afs_apb_e ap;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    afs_pkg::afs_cfg_s cfg;
    logic [3:0] gcfg;
    logic [1:0] gdat;
    logic [1:0] gin;
    logic rxi_m;
    logic rxi_s;
    logic txi_m;
    logic txi_s;
    logic rxd_m;
    logic rxd_s;
    logic txd_m;
    logic txd_s;
    logic if1_m;
    logic if1_s;
    afs_pkg::afs_pin_s rx_pin;
    afs_pkg::afs_pin_s tx_pin;
  } afs_top_s;

  afs_top_s st_reg;
  afs_top_s st_next;
  logic [7:0] addr;
  logic hit;
  logic [31:0] rd_mux;
  logic wr_commit;
  afs_pkg::afs_gmode_e gm_rx;
  afs_pkg::afs_gmode_e gm_tx;
  logic lk_rx_drive;
  logic lk_tx_drive;
  logic lk_if1;

  // Bit-clock side: frame sync routing and flag timing
  afs_link u_link (
    .lclk(link_clk),
    .nrst(nrst),
    .cfg(st_reg.cfg),
    .rx_pin_in(rx_frame_sync_pin_in),
    .tx_pin_in(tx_frame_sync_pin_in),
    .core_src(core_src),
    .slot_start(slot_start),
    .rx_fs_core(rx_fs_core),
    .tx_fs_core(tx_fs_core),
    .rx_drive(lk_rx_drive),
    .tx_drive(lk_tx_drive),
    .if1(lk_if1)
  );

  // Address decode and read data
  always_comb begin
    addr = 8'(paddr);
    hit = 1'b1;
    rd_mux = afs_pkg::RDATA_RST;
    if (ADDR_W > 8 && (paddr >> 8) != '0) begin
      hit = 1'b0;
    end else begin
      case (addr)
        afs_pkg::OFS_CTRL: begin
          rd_mux[afs_pkg::CTRL_SYNC] = st_reg.cfg.sync;
          rd_mux[afs_pkg::CTRL_TX_EXT_BUFFER_OPTION] = st_reg.cfg.tx_ext_buffer_option;
          rd_mux[afs_pkg::CTRL_OF1] = st_reg.cfg.of1;
          rd_mux[afs_pkg::CTRL_NETW] = st_reg.cfg.netw;
          rd_mux[afs_pkg::CTRL_PEN] = st_reg.cfg.pen;
        end
        afs_pkg::OFS_RXCLK: begin
          rd_mux[afs_pkg::DIR_BIT] = st_reg.cfg.rx_fs_direction;
        end
        afs_pkg::OFS_TXCLK: begin
          rd_mux[afs_pkg::DIR_BIT] = st_reg.cfg.tx_fs_direction;
        end
        afs_pkg::OFS_STAT: begin
          rd_mux[afs_pkg::STAT_IF1] = st_reg.if1_s;
        end
        afs_pkg::OFS_GCFG: begin
          rd_mux[3:0] = st_reg.gcfg;
        end
        afs_pkg::OFS_GDAT: begin
          rd_mux[afs_pkg::GDAT_OUT_LSB +: 2] = st_reg.gdat;
          rd_mux[afs_pkg::GDAT_IN_LSB +: 2] = st_reg.gin;
        end
        default: begin
          hit = 1'b0;
        end
      endcase
    end
  end

  // Next state: bus answer, register writes, crossings, pin drive
  always_comb begin
    st_next = st_reg;
    wr_commit = 1'b0;
    gm_rx = afs_pkg::afs_gmode_e'(st_reg.gcfg[afs_pkg::GCFG_RX_LSB +: 2]);
    gm_tx = afs_pkg::afs_gmode_e'(st_reg.gcfg[afs_pkg::GCFG_TX_LSB +: 2]);
    // Zero-wait APB answer: pready rises in the first access cycle
    case (st_reg.ap)
      afs_pkg::AFS_AP_IDLE: begin
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
          st_next.ap = afs_pkg::AFS_AP_RESP;
          st_next.pready = 1'b1;
          st_next.pslverr = ~hit;
          st_next.prdata = (pwrite || !hit) ? afs_pkg::RDATA_RST : rd_mux;
        end
      end
      afs_pkg::AFS_AP_RESP: begin
        st_next.prdata = afs_pkg::RDATA_RST;
        st_next.ap = afs_pkg::AFS_AP_IDLE;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        wr_commit = psel & penable & pwrite & hit;
      end
      default: begin
        st_next.prdata = afs_pkg::RDATA_RST;
        st_next.ap = afs_pkg::AFS_AP_IDLE;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
      end
    endcase
    // Register writes at the completing edge only
    if (wr_commit) begin
      case (addr)
        afs_pkg::OFS_CTRL: begin
          st_next.cfg.sync = pwdata[afs_pkg::CTRL_SYNC];
          st_next.cfg.tx_ext_buffer_option = pwdata[afs_pkg::CTRL_TX_EXT_BUFFER_OPTION];
          st_next.cfg.of1 = pwdata[afs_pkg::CTRL_OF1];
          st_next.cfg.netw = pwdata[afs_pkg::CTRL_NETW];
          st_next.cfg.pen = pwdata[afs_pkg::CTRL_PEN];
        end
        afs_pkg::OFS_RXCLK: begin
          st_next.cfg.rx_fs_direction = pwdata[afs_pkg::DIR_BIT];
        end
        afs_pkg::OFS_TXCLK: begin
          st_next.cfg.tx_fs_direction = pwdata[afs_pkg::DIR_BIT];
        end
        afs_pkg::OFS_GCFG: begin
          st_next.gcfg = pwdata[3:0];
        end
        afs_pkg::OFS_GDAT: begin
          st_next.gdat = pwdata[afs_pkg::GDAT_OUT_LSB +: 2];
        end
        default: begin
          st_next.gdat = st_reg.gdat;
        end
      endcase
    end
    // Two-stage synchronisers for pins and link-domain values
    st_next.rxi_m = rx_frame_sync_pin_in;
    st_next.rxi_s = st_reg.rxi_m;
    st_next.txi_m = tx_frame_sync_pin_in;
    st_next.txi_s = st_reg.txi_m;
    st_next.rxd_m = lk_rx_drive;
    st_next.rxd_s = st_reg.rxd_m;
    st_next.txd_m = lk_tx_drive;
    st_next.txd_s = st_reg.txd_m;
    st_next.if1_m = lk_if1;
    st_next.if1_s = st_reg.if1_m;
    // GPIO inputs sampled only in input mode
    st_next.gin[0] = (!st_reg.cfg.pen && gm_rx == afs_pkg::AFS_G_IN) & st_reg.rxi_s;
    st_next.gin[1] = (!st_reg.cfg.pen && gm_tx == afs_pkg::AFS_G_IN) & st_reg.txi_s;
    // Receive frame sync pin function select
    if (!st_reg.cfg.pen) begin
      st_next.rx_pin.oe = (gm_rx == afs_pkg::AFS_G_OUT);
      st_next.rx_pin.dout = (gm_rx == afs_pkg::AFS_G_OUT) & st_reg.gdat[0];
    end else if (!st_reg.cfg.sync) begin
      st_next.rx_pin.oe = st_reg.cfg.rx_fs_direction;
      st_next.rx_pin.dout = st_reg.cfg.rx_fs_direction & st_reg.rxd_s;
    end else if (!st_reg.cfg.tx_ext_buffer_option) begin
      st_next.rx_pin.oe = st_reg.cfg.rx_fs_direction;
      st_next.rx_pin.dout = st_reg.cfg.rx_fs_direction & st_reg.rxd_s;
    end else if (st_reg.cfg.rx_fs_direction) begin
      st_next.rx_pin.oe = 1'b1;
      st_next.rx_pin.dout = st_reg.rxd_s;
    end else begin
      st_next.rx_pin.oe = 1'b0;
      st_next.rx_pin.dout = 1'b0;
    end
    // Transmit frame sync pin function select
    if (!st_reg.cfg.pen) begin
      st_next.tx_pin.oe = (gm_tx == afs_pkg::AFS_G_OUT);
      st_next.tx_pin.dout = (gm_tx == afs_pkg::AFS_G_OUT) & st_reg.gdat[1];
    end else begin
      st_next.tx_pin.oe = st_reg.cfg.tx_fs_direction;
      st_next.tx_pin.dout = st_reg.cfg.tx_fs_direction & st_reg.txd_s;
    end
  end

  // Core-domain state register; reset leaves GPIO disconnected
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign rx_frame_sync_pin = st_reg.rx_pin;
  assign tx_frame_sync_pin = st_reg.tx_pin;

  // Pin function and APB answer checks
  disc_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.cfg.pen && gm_rx == afs_pkg::AFS_G_DISC) |=> !rx_frame_sync_pin.oe && st_reg.gin[0] == 1'b0)
    else $error("disconnected receive pin drives or samples");

  async_rxdir_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.cfg.pen && !st_reg.cfg.sync) |=> rx_frame_sync_pin.oe == $past(st_reg.cfg.rx_fs_direction))
    else $error("async receive frame sync direction wrong");

  flag_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.cfg.pen && st_reg.cfg.sync && !st_reg.cfg.tx_ext_buffer_option)
    |=> rx_frame_sync_pin.oe == $past(st_reg.cfg.rx_fs_direction) && rx_frame_sync_pin.dout == ($past(st_reg.cfg.rx_fs_direction)
    && $past(st_reg.rxd_s)))
    else $error("serial flag direction wrong");

  buf_enable_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.cfg.pen && st_reg.cfg.sync && st_reg.cfg.tx_ext_buffer_option && st_reg.cfg.rx_fs_direction)
    |=> rx_frame_sync_pin.oe && rx_frame_sync_pin.dout == $past(st_reg.rxd_s))
    else $error("buffer enable not driven");

  tx_dir_a: assert property (@(posedge clk) disable iff (!nrst)
    st_reg.cfg.pen |=> tx_frame_sync_pin.oe == $past(st_reg.cfg.tx_fs_direction))
    else $error("transmit frame sync direction wrong");

  gpio_out_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.cfg.pen && gm_tx == afs_pkg::AFS_G_OUT) |=> tx_frame_sync_pin.oe
    && tx_frame_sync_pin.dout == $past(st_reg.gdat[1]))
    else $error("GPIO output not driven");

  apb_answer_a: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");

  apb_error_a: assert property (@(posedge clk) disable iff (!nrst)
    (psel && !penable && !pready) |=> pslverr != $past(hit))
    else $error("APB error flag does not match address decode");

  rdata_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !pready |-> prdata == afs_pkg::RDATA_RST)
    else $error("read data stands outside the answer cycle");

  async_rxdata_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.cfg.pen && !st_reg.cfg.sync && st_reg.cfg.rx_fs_direction)
    |=> rx_frame_sync_pin.dout == $past(st_reg.rxd_s))
    else $error("async receive frame sync not driven from the core");

  buf_refused_a: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.cfg.pen && st_reg.cfg.sync && st_reg.cfg.tx_ext_buffer_option && !st_reg.cfg.rx_fs_direction) |=> !rx_frame_sync_pin.oe)
    else $error("receive pin driven with buffer option and input direction");

  gpio_in_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.cfg.pen && gm_tx == afs_pkg::AFS_G_IN) |=> st_reg.gin[1] == $past(st_reg.txi_s))
    else $error("GPIO input not sampled");

  tx_disc_a: assert property (@(posedge clk) disable iff (!nrst)
    (!st_reg.cfg.pen && gm_tx != afs_pkg::AFS_G_OUT) |=> !tx_frame_sync_pin.oe && !tx_frame_sync_pin.dout)
    else $error("transmit pin driven while not a GPIO output");

endmodule

// file: hw/afs_pkg.sv
package afs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RXCLK = 8'h04;
  localparam logic [7:0] OFS_TXCLK = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_GCFG = 8'h10;
  localparam logic [7:0] OFS_GDAT = 8'h14;

  // Field positions in the common control register
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_TX_EXT_BUFFER_OPTION = 1;
  localparam int CTRL_OF1 = 2;
  localparam int CTRL_NETW = 3;
  localparam int CTRL_PEN = 4;
  // Direction bit in both clock control registers
  localparam int DIR_BIT = 0;
  // Input flag bit in the common status register
  localparam int STAT_IF1 = 0;
  // GPIO mode fields, two bits per pin
  localparam int GCFG_RX_LSB = 0;
  localparam int GCFG_TX_LSB = 2;
  // GPIO data: output values low, sampled inputs above
  localparam int GDAT_OUT_LSB = 0;
  localparam int GDAT_IN_LSB = 2;

  // Reset values
  localparam logic [3:0] GCFG_RST = 4'h0;
  localparam logic [1:0] GDAT_RST = 2'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Per-pin GPIO mode
  typedef enum logic [1:0] {
    AFS_G_DISC = 2'h0,
    AFS_G_IN = 2'h1,
    AFS_G_OUT = 2'h2
  } afs_gmode_e;

  // APB answer sequencer
  typedef enum logic {
    AFS_AP_IDLE = 1'b0,
    AFS_AP_RESP = 1'b1
  } afs_apb_e;

  // Software configuration seen by the pin logic
  typedef struct packed {
    logic pen;
    logic netw;
    logic of1;
    logic tx_ext_buffer_option;
    logic sync;
    logic rx_fs_direction;
    logic tx_fs_direction;
  } afs_cfg_s;

  localparam afs_cfg_s CFG_RST = '0;

  // One two-way pin as driven by the block
  typedef struct packed {
    logic dout;
    logic oe;
  } afs_pin_s;

  // Frame sync sources and transmitter buffer enable from the serial port core, link domain
  typedef struct packed {
    logic rx_fs;
    logic tx_fs;
    logic buf_en;
  } afs_core_s;

endpackage

// file: test/afs_codec_model.sv
`timescale 1ns/1ps
module afs_codec_model (
  input wire logic lclk,
  input wire logic rx_en,
  input wire logic rx_val,
  input wire logic tx_en,
  input wire logic tx_val,
  input wire afs_pkg::afs_pin_s rx_pin,
  input wire afs_pkg::afs_pin_s tx_pin,
  output logic rx_level,
  output logic tx_level
);
  logic [3:0] drv = 4'h0;
  // Codec moves its lines only on the bit clock
  always @(posedge lclk) begin
    drv <= {rx_en, rx_val, tx_en, tx_val};
  end
  // Wire level: block driver, else codec, else pull-down
  assign rx_level = rx_pin.oe ? rx_pin.dout : (drv[3] & drv[2]);
  assign tx_level = tx_pin.oe ? tx_pin.dout : (drv[1] & drv[0]);
endmodule

// file: test/audio_port_frame_sync_pins_tb.sv
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module audio_port_frame_sync_pins_tb;
  logic clk = 1'b0;
  logic nrst;
  logic lck = 1'b0;
  logic run = 1'b0;
  logic run_q = 1'b0;
  logic link_clk;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_in;
  logic tx_in;
  afs_pkg::afs_pin_s rx_pin;
  afs_pkg::afs_pin_s tx_pin;
  afs_pkg::afs_core_s core_src = '0;
  logic slot_start = 1'b0;
  logic rx_fs_core;
  logic tx_fs_core;
  logic rx_en = 1'b0;
  logic rx_val = 1'b0;
  logic tx_en = 1'b0;
  logic tx_val = 1'b0;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int checks = 0;
  int cyc = 0;

  // Core clock and gated bit clock, glitch-free gating on the low phase
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #6 lck = ~lck;
  end
  always @(negedge lck) run_q <= run;
  assign link_clk = lck & run_q;

  afs_pins DUT (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
    .rx_frame_sync_pin_in(rx_in), .tx_frame_sync_pin_in(tx_in), .rx_frame_sync_pin(rx_pin),
    .tx_frame_sync_pin(tx_pin), .core_src(core_src), .slot_start(slot_start), .rx_fs_core(rx_fs_core),
    .tx_fs_core(tx_fs_core));
  afs_codec_model codec (.lclk(link_clk), .rx_en(rx_en), .rx_val(rx_val), .tx_en(tx_en), .tx_val(tx_val),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_level(rx_in), .tx_level(tx_in));

  task automatic conclude;
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      conclude();
    end
  end

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK("wr_err", e, 1'b0)
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(nm, q, x)
  endtask
  task automatic settle;
    repeat (24) @(posedge clk);
  endtask
  task automatic core(input logic [2:0] v);
    @(posedge link_clk);
    core_src <= v;
  endtask
  task automatic pins(input logic ro, input logic rv, input logic to, input logic tv);
    `CHK("rx_oe", rx_pin.oe, ro)
    if (ro) `CHK("rx_dout", rx_pin.dout, rv)
    `CHK("tx_oe", tx_pin.oe, to)
    if (to) `CHK("tx_dout", tx_pin.dout, tv)
  endtask
  task automatic do_reset;
    run <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    repeat (12) @(posedge clk);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("rst_rdata", prdata, afs_pkg::RDATA_RST)
    nrst <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
  endtask

  initial begin
    nrst <= 1'b0; // Real falling edge so the idle link domain resets too
    repeat (12) @(posedge clk);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    nrst <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    rd("ctrl_rst", afs_pkg::OFS_CTRL, 32'h0);
    rd("gcfg_rst", afs_pkg::OFS_GCFG, 32'(afs_pkg::GCFG_RST));
    // Status is read-only; unmapped address is refused
    wr(afs_pkg::OFS_STAT, 32'h1);
    rd("stat_ro", afs_pkg::OFS_STAT, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped_err", e, 1'b1)
    `CHK("unmapped_data", q, 32'h0)
    // Disconnected pins neither drive nor sample
    rx_en <= 1'b1;
    rx_val <= 1'b1;
    tx_en <= 1'b1;
    tx_val <= 1'b1;
    settle();
    rd("gdat_disc", afs_pkg::OFS_GDAT, 32'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    // GPIO inputs
    wr(afs_pkg::OFS_GCFG, 32'h5);
    settle();
    rd("gdat_in", afs_pkg::OFS_GDAT, 32'hC);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    // GPIO outputs, every value pair
    rx_en <= 1'b0;
    tx_en <= 1'b0;
    wr(afs_pkg::OFS_GCFG, 32'hA);
    for (int v = 0; v < 4; v++) begin
      wr(afs_pkg::OFS_GDAT, 32'(v));
      settle();
      pins(1'b1, v[0], 1'b1, v[1]);
      rd("gdat_out", afs_pkg::OFS_GDAT, 32'(v));
    end
    // Receive pin output, transmit pin code 3 disconnected
    wr(afs_pkg::OFS_GCFG, 32'hE);
    settle();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    // Async serial mode, both frame syncs from the core
    wr(afs_pkg::OFS_RXCLK, 32'h1);
    wr(afs_pkg::OFS_TXCLK, 32'h1);
    wr(afs_pkg::OFS_CTRL, 32'h10);
    for (int v = 0; v < 4; v++) begin
      core({v[0], v[1], 1'b0});
      settle();
      pins(1'b1, v[0], 1'b1, v[1]);
      `CHK("rx_fs_core", rx_fs_core, v[0])
      `CHK("tx_fs_core", tx_fs_core, v[1])
    end
    // Pins as inputs: receivers follow the receive pin
    core(3'b000);
    wr(afs_pkg::OFS_RXCLK, 32'h0);
    wr(afs_pkg::OFS_TXCLK, 32'h0);
    rx_en <= 1'b1;
    rx_val <= 1'b1;
    tx_en <= 1'b1;
    tx_val <= 1'b0;
    settle();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("rx_fs_async", rx_fs_core, 1'b1)
    `CHK("tx_fs_async", tx_fs_core, 1'b0)
    // Sync mode: receivers take the transmit pin; receive pin is input flag
    wr(afs_pkg::OFS_CTRL, 32'h11);
    settle();
    `CHK("rx_fs_sync0", rx_fs_core, 1'b0)
    rd("if1_idle", afs_pkg::OFS_STAT, 32'h0);
    tx_val <= 1'b1;
    settle();
    `CHK("rx_fs_sync1", rx_fs_core, 1'b1)
    `CHK("rx_oe_in", rx_pin.oe, 1'b0)
    rd("if1_event", afs_pkg::OFS_STAT, 32'h1);
    rx_val <= 1'b0;
    settle();
    rd("if1_hold", afs_pkg::OFS_STAT, 32'h1);
    tx_val <= 1'b0;
    settle();
    tx_val <= 1'b1;
    settle();
    rd("if1_resample", afs_pkg::OFS_STAT, 32'h0);
    // Output flag in normal mode
    rx_en <= 1'b0;
    wr(afs_pkg::OFS_RXCLK, 32'h1);
    wr(afs_pkg::OFS_CTRL, 32'h15);
    settle();
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    tx_val <= 1'b0;
    settle();
    tx_val <= 1'b1;
    settle();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    // Network mode: frame sync ignored, slot updates the flag
    wr(afs_pkg::OFS_CTRL, 32'h19);
    tx_val <= 1'b0;
    settle();
    tx_val <= 1'b1;
    settle();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    @(posedge link_clk);
    slot_start <= 1'b1;
    @(posedge link_clk);
    slot_start <= 1'b0;
    settle();
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    // Transmitter buffer enable on the receive pin
    wr(afs_pkg::OFS_CTRL, 32'h13);
    core(3'b001);
    settle();
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    core(3'b000);
    settle();
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    wr(afs_pkg::OFS_RXCLK, 32'h0);
    settle();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    // Second reset while the transmit pin drives
    tx_en <= 1'b0;
    wr(afs_pkg::OFS_TXCLK, 32'h1);
    settle();
    `CHK("tx_oe_pre", tx_pin.oe, 1'b1)
    do_reset();
    rd("ctrl_rst2", afs_pkg::OFS_CTRL, 32'h0);
    rd("txclk_rst2", afs_pkg::OFS_TXCLK, 32'h0);
    settle();
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    conclude();
  end
endmodule
